// File: hw/phy_mode_pkg.sv
// phy_mode_pkg: offsets, field positions, reset values and counts for the phy mode control block
// assumes: included before phy_mode_control; apb data 32 bits
package phy_mode_pkg;
	localparam logic [11:0] phy_mode_control_off   = 12'h080;
	localparam logic [11:0] phy_mode_status_off    = 12'h084;
	localparam logic [11:0] strap_config_off       = 12'h088;
	localparam int          reg_width              = 16;
	localparam int          bit_sw_reset           = 15;
	localparam int          bit_loopback           = 14;
	localparam int          bit_speed_select       = 13;
	localparam int          bit_autoneg_enable     = 12;
	localparam int          bit_power_down         = 11;
	localparam int          bit_isolate            = 10;
	localparam int          bit_autoneg_restart    = 9;
	localparam int          bit_duplex_select      = 8;
	localparam int          bit_collision_test     = 7;
	localparam int          strap_sel_lsb          = 13;
	localparam int          strap_sel_width        = 3;
	localparam logic [15:0] control_rw_mask        = 16'h7D80;
	localparam logic [15:0] control_reset_value    = 16'h0000;
	localparam logic [2:0]  strap_sel_reset_value  = 3'h7;
	localparam int          sw_reset_time_ns       = 1000;
	localparam int          clk_period_ns          = 10;
	localparam int          sw_reset_cycles        = (sw_reset_time_ns + clk_period_ns - 1) / clk_period_ns;
	localparam logic [15:0] status_fixed_value     = 16'h0000;
endpackage

// File: hw/phy_mode_control.sv
// phy_mode_control: phy mode control register bank behind an apb slave
// assumes: single clock i_mclk; strap pins and events are asynchronous and get synchronised here
`timescale 1ns/1ns
module phy_mode_control
	import phy_mode_pkg::*;
#(
	parameter int sw_reset_len = sw_reset_cycles
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [2:0]  i_autoneg_strap_select,
	input  wire logic        i_link_up,
	input  wire logic        i_remote_fault,
	input  wire logic        i_autoneg_done,
	output logic             o_phy_reset,
	output logic             o_loopback,
	output logic             o_speed_100,
	output logic             o_full_duplex,
	output logic             o_autoneg_enable,
	output logic             o_autoneg_restart,
	output logic             o_power_down,
	output logic             o_isolate,
	output logic             o_collision_test
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release and input synchronisers

	logic        rst_meta_reg;
	logic        rst_sync_reg;
	wire  logic  rst_n;
	wire  logic [5:0] in_raw;
	wire  logic [5:0] in_sync;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	assign in_raw = {i_autoneg_strap_select, i_link_up, i_remote_fault, i_autoneg_done};

	// one two-stage synchroniser per asynchronous input bit
	for (genvar g = 0; g < 6; g++) begin : g_sync
		logic meta_reg;
		logic sync_reg;
		always_ff @(posedge i_mclk or negedge rst_n) begin
			if (!rst_n) begin
				meta_reg <= 1'b0;
				sync_reg <= 1'b0;
			end else begin
				meta_reg <= in_raw[g];
				sync_reg <= meta_reg;
			end
		end
		assign in_sync[g] = sync_reg;
	end

	wire logic [2:0] strap_sync;
	wire logic       link_up_sync;
	wire logic       remote_fault_sync;
	wire logic       autoneg_done_sync;
	assign strap_sync        = in_sync[5:3];
	assign link_up_sync      = in_sync[2];
	assign remote_fault_sync = in_sync[1];
	assign autoneg_done_sync = in_sync[0];

	////////////////////////////////////////////////////////////////////////////////
	// strap decode

	function automatic logic [1:0] strap_defaults(input logic [2:0] sel);
		// returns {autoneg_enable, speed_100}; duplex follows the same field
		case (sel)
			3'h0:    strap_defaults = 2'b00;
			3'h1:    strap_defaults = 2'b00;
			3'h2:    strap_defaults = 2'b01;
			3'h3:    strap_defaults = 2'b01;
			default: strap_defaults = 2'b11;
		endcase
	endfunction

	function automatic logic strap_duplex(input logic [2:0] sel);
		strap_duplex = sel[0] | (sel == 3'h7);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	typedef enum logic [1:0] {st_run, st_sw_reset, st_load_strap} reset_state_e;

	wire logic setup_phase;
	wire logic wr_access;
	wire logic rd_access;
	wire logic hit_control;
	wire logic hit_status;
	wire logic hit_strap;
	wire logic addr_mapped;
	wire logic wr_control;
	wire logic rd_status;
	wire logic wr_strap;

	assign setup_phase = i_psel & ~i_penable;
	assign wr_access   = setup_phase & i_pwrite;
	assign rd_access   = setup_phase & ~i_pwrite;
	assign hit_control = (i_paddr == phy_mode_control_off);
	assign hit_status  = (i_paddr == phy_mode_status_off);
	assign hit_strap   = (i_paddr == strap_config_off);
	assign addr_mapped = hit_control | hit_status | hit_strap;
	assign wr_control  = wr_access & hit_control & (|i_pstrb[1:0]);
	assign rd_status   = rd_access & hit_status;
	assign wr_strap    = wr_access & hit_strap & i_pstrb[0];

	////////////////////////////////////////////////////////////////////////////////
	// control register

	reset_state_e rst_state_reg;
	reset_state_e rst_state_next;
	logic [15:0]  control_reg;
	logic [15:0]  control_next;
	logic [2:0]   strap_reg;
	logic [15:0]  rst_cnt_reg;
	logic [15:0]  rst_cnt_next;
	logic         restart_reg;
	logic         restart_next;

	wire logic [15:0] byte_mask;
	wire logic [15:0] wr_value;
	wire logic [15:0] strap_value;
	wire logic [1:0]  strap_an_speed;
	wire logic        sw_reset_req;

	assign byte_mask    = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
	assign wr_value     = (control_reg & ~byte_mask) | (i_pwdata[15:0] & byte_mask);
	assign sw_reset_req = wr_control & i_pstrb[1] & i_pwdata[bit_sw_reset];
	assign strap_an_speed = strap_defaults(strap_reg);
	assign strap_value  = control_reset_value
		| ({15'h0000, strap_an_speed[1]} << bit_autoneg_enable)
		| ({15'h0000, strap_an_speed[0]} << bit_speed_select)
		| ({15'h0000, strap_duplex(strap_reg)} << bit_duplex_select);

	always_comb begin
		rst_state_next = rst_state_reg;
		control_next   = control_reg;
		rst_cnt_next   = rst_cnt_reg;
		restart_next   = restart_reg;
		if (restart_reg && autoneg_done_sync) begin
			restart_next = 1'b0;
		end
		case (rst_state_reg)
			st_run: begin
				if (sw_reset_req) begin
					rst_state_next = st_sw_reset;
					rst_cnt_next   = 16'(sw_reset_len);
					control_next   = 16'h0000;
					control_next[bit_sw_reset] = 1'b1;
				end else if (wr_control) begin
					control_next = wr_value & control_rw_mask;
					if (wr_value[bit_autoneg_restart] && wr_value[bit_autoneg_enable]) begin
						restart_next = 1'b1;
					end
				end
			end
			st_sw_reset: begin
				if (rst_cnt_reg <= 16'h0001) begin
					rst_state_next = st_load_strap;
				end else begin
					rst_cnt_next = rst_cnt_reg - 16'h0001;
				end
			end
			st_load_strap: begin
				rst_state_next = st_run;
				control_next   = strap_value;
				restart_next   = 1'b0;
			end
			default: begin
				rst_state_next = st_run;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_state_reg <= st_load_strap;
			rst_cnt_reg   <= 16'h0000;
		end else begin
			rst_state_reg <= rst_state_next;
			rst_cnt_reg   <= rst_cnt_next;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= control_reset_value;
		end else begin
			control_reg <= control_next;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= restart_next;
		end
	end

	// strap latch: loaded with strap_sel_reset_value at reset, caught from the pins on each software reset
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_reg <= strap_sel_reset_value;
		end else if (rst_state_reg == st_sw_reset) begin
			strap_reg <= strap_sync;
		end else if (wr_strap) begin
			strap_reg <= i_pwdata[strap_sel_lsb +: strap_sel_width];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// latched status: link latched_low, remote fault latched_high

	logic link_latched_low_reg;
	logic fault_latched_high_reg;

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			link_latched_low_reg <= 1'b0;
		end else if (!link_up_sync) begin
			link_latched_low_reg <= 1'b0;
		end else if (rd_status) begin
			link_latched_low_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_latched_high_reg <= 1'b0;
		end else if (remote_fault_sync) begin
			fault_latched_high_reg <= 1'b1;
		end else if (rd_status) begin
			fault_latched_high_reg <= 1'b0;
		end
	end

	wire logic [15:0] status_value;
	assign status_value = status_fixed_value
		| {13'h0000, fault_latched_high_reg, link_latched_low_reg, 1'b0};

	////////////////////////////////////////////////////////////////////////////////
	// apb read data and response

	wire logic [15:0] control_view;
	wire logic [15:0] rd_value;
	assign control_view = {control_reg[15:10], restart_reg, control_reg[8:0]};
	assign rd_value     = hit_control ? control_view
		: hit_status ? status_value
		: hit_strap  ? {strap_reg, 13'h0000}
		: 16'h0000;

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= setup_phase;
			o_pslverr <= setup_phase & ~addr_mapped;
			if (rd_access) begin
				o_prdata <= {16'h0000, rd_value};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode outputs

	wire logic an_on;
	assign an_on = control_reg[bit_autoneg_enable];

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_phy_reset       <= 1'b1;
			o_autoneg_restart <= 1'b0;
		end else begin
			o_phy_reset       <= (rst_state_reg != st_run);
			o_autoneg_restart <= restart_reg;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_speed_100      <= 1'b0;
			o_full_duplex    <= 1'b0;
			o_autoneg_enable <= 1'b0;
		end else begin
			o_speed_100      <= an_on | control_reg[bit_speed_select];
			o_full_duplex    <= an_on | control_reg[bit_duplex_select];
			o_autoneg_enable <= an_on;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_loopback       <= 1'b0;
			o_power_down     <= 1'b0;
			o_isolate        <= 1'b0;
			o_collision_test <= 1'b0;
		end else begin
			o_loopback       <= control_reg[bit_loopback];
			o_power_down     <= control_reg[bit_power_down];
			o_isolate        <= control_reg[bit_isolate];
			o_collision_test <= control_reg[bit_collision_test];
		end
	end

endmodule // phy_mode_control

// File: sim/phy_mode_control_sva.sv
// phy_mode_control_sva: port-level assertions for the phy mode control block
// assumes: bound to phy_mode_control; full byte strobes on control writes
`timescale 1ns/1ns
module phy_mode_control_sva
	import phy_mode_pkg::*;
#(
	parameter int sw_reset_len = sw_reset_cycles
) (
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0]  i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_phy_reset,
	input wire logic        o_loopback,
	input wire logic        o_speed_100,
	input wire logic        o_full_duplex,
	input wire logic        o_autoneg_enable,
	input wire logic        o_power_down
);
default clocking @(posedge i_mclk); endclocking
default disable iff (!i_rst_n);
////////////////////////////////////////////////////////////////////////////////
wire setup = i_psel & !i_penable;
wire bad = (i_paddr != phy_mode_control_off) & (i_paddr != phy_mode_status_off) & (i_paddr != strap_config_off);
wire wr = setup & i_pwrite & (i_paddr == phy_mode_control_off) & (i_pstrb[1:0] == 2'b11) & !i_pwdata[15] & !o_phy_reset;
logic [15:0] wd;
always_ff @(posedge i_mclk) begin
	if (wr) wd <= i_pwdata[15:0];
end
////////////////////////////////////////////////////////////////////////////////
property p_upper; o_pready |-> o_prdata[31:16] == 16'h0000; endproperty
a_upper: assert property (p_upper) else $error("upper half not zero");
property p_unmapped; setup & bad |=> o_pslverr && ($past(i_pwrite) || o_prdata == 32'h0000_0000); endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
property p_reserved; setup & !i_pwrite & (i_paddr == phy_mode_control_off) |=> o_pready && o_prdata[6:0] == 7'h00; endproperty
a_reserved: assert property (p_reserved) else $error("reserved bits set");
property p_an; o_autoneg_enable |-> o_speed_100 && o_full_duplex; endproperty
a_an: assert property (p_an) else $error("autoneg not overriding");
property p_rst_hold; $rose(o_phy_reset) |-> o_phy_reset[*3]; endproperty
a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
property p_rst_end; $rose(o_phy_reset) |-> ##[1:200] !o_phy_reset; endproperty
a_rst_end: assert property (p_rst_end) else $error("reset never ends");
property p_loop; wr |-> ##2 o_loopback == wd[14]; endproperty
a_loop: assert property (p_loop) else $error("loopback wrong");
property p_pdown; wr |-> ##2 o_power_down == wd[11]; endproperty
a_pdown: assert property (p_pdown) else $error("power down wrong");
property p_speed; wr |-> ##2 o_speed_100 == (wd[12] | wd[13]); endproperty
a_speed: assert property (p_speed) else $error("speed wrong");
property p_duplex; wr |-> ##2 o_full_duplex == (wd[12] | wd[8]); endproperty
a_duplex: assert property (p_duplex) else $error("duplex wrong");
endmodule // phy_mode_control_sva
bind phy_mode_control phy_mode_control_sva #(.sw_reset_len(sw_reset_len)) u_sva (.i_mclk, .i_rst_n, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .o_phy_reset,
	.o_loopback, .o_speed_100, .o_full_duplex, .o_autoneg_enable, .o_power_down);

// File: sim/tb_phy_mode_control.sv
// tb_phy_mode_control: self-checking bench driving apb, straps and status events
// assumes: phy_mode_pkg compiled first; checker bound by its own file
`timescale 1ns/1ns
module tb_phy_mode_control;
import phy_mode_pkg::*;
logic        i_mclk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
logic [11:0] i_paddr = 12'h000;
logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
logic [2:0]  strap = 3'h5;
logic        link = 1, fault = 0, an_done = 0, err;
logic        o_pready, o_pslverr, o_phy_reset, o_loopback, o_speed_100, o_full_duplex, o_autoneg_enable, o_power_down;
logic        o_autoneg_restart, o_isolate, o_collision_test;
logic [3:0]  strb = 4'hF;
int          err_count = 0, tests_run = 0;
logic [31:0] seed = 32'd18039, d;
always #5 i_mclk = ~i_mclk;
phy_mode_control #(.sw_reset_len(8)) dut (.i_mclk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
	.i_pstrb(strb), .o_prdata, .o_pready, .o_pslverr, .i_autoneg_strap_select(strap), .i_link_up(link),
	.i_remote_fault(fault), .i_autoneg_done(an_done), .o_phy_reset, .o_loopback, .o_speed_100, .o_full_duplex,
	.o_autoneg_enable, .o_autoneg_restart, .o_power_down, .o_isolate, .o_collision_test);
////////////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] xs();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction
function automatic logic [31:0] exp_ctl(input logic [2:0] s);
	exp_ctl = 32'h0000_0000;
	exp_ctl[13] = s >= 3'h2;
	exp_ctl[12] = s >= 3'h4;
	exp_ctl[8] = s[0] | (s == 3'h7);
endfunction
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	tests_run++;
	if (got !== exp) begin
		err_count++;
		$display("BAD %0t got %h expected %h", $time, got, exp);
	end
endtask
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
	i_psel <= 1;
	i_pwrite <= w;
	i_paddr <= a;
	i_pwdata <= wd;
	@(posedge i_mclk);
	i_penable <= 1;
	do @(posedge i_mclk); while (o_pready !== 1'b1);
	rd = o_prdata;
	err = o_pslverr;
	i_psel <= 0;
	i_penable <= 0;
	@(posedge i_mclk);
endtask
task automatic end_sim();
	$display("tests_run %0d err_count %0d", tests_run, err_count);
	if (err_count == 0 && tests_run > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	#200000;
	err_count++;
	end_sim();
end
initial begin
	repeat (4) @(posedge i_mclk);
	i_rst_n <= 1;
	repeat (6) @(posedge i_mclk);
	apb(0, phy_mode_control_off, 0);
	chk(rd, exp_ctl(strap_sel_reset_value));
	chk(o_phy_reset, 1'b0);
	$display("strap defaults done");
	for (int i = 0; i < 12; i++) begin
		d = (i == 0) ? 32'hFFFF_5DFF : (i == 1) ? 32'h0000_0000 : xs() & 32'hFFFF_7DFF; // bits 15 and 9 kept clear: no software reset, no autoneg restart
		apb(1, phy_mode_control_off, d);
		apb(0, phy_mode_control_off, 0);
		chk(rd, d & {16'h0000, control_rw_mask});
		chk({o_loopback, o_power_down}, {d[14], d[11]});
		chk(o_speed_100, d[12] | d[13]);
		chk(o_full_duplex, d[12] | d[8]);
		chk({o_isolate, o_collision_test}, {d[10], d[7]});
	end
	$display("random control writes done");
	strb <= 4'h1;
	apb(1, phy_mode_control_off, 32'h0000_FFFF);
	strb <= 4'hF;
	apb(0, phy_mode_control_off, 0);
	chk(rd, (d & 32'h0000_7D00) | 32'h0000_0080);
	apb(1, 12'h0FC, 32'hFFFF_FFFF);
	chk(err, 1'b1);
	apb(0, 12'h0FC, 0);
	chk(err, 1'b1);
	chk(rd, 32'h0000_0000);
	apb(0, phy_mode_control_off, 0);
	chk(rd, (d & 32'h0000_7D00) | 32'h0000_0080);
	$display("strobe and unmapped done");
	apb(1, phy_mode_control_off, 32'h0000_1200);
	apb(0, phy_mode_control_off, 0);
	chk(rd[9], 1'b1);
	chk(o_autoneg_restart, 1'b1);
	an_done <= 1;
	repeat (6) @(posedge i_mclk);
	apb(0, phy_mode_control_off, 0);
	chk(rd[9], 1'b0);
	chk(o_autoneg_restart, 1'b0);
	an_done <= 0;
	$display("self clearing done");
	strap <= 3'h2;
	repeat (4) @(posedge i_mclk);
	apb(1, phy_mode_control_off, 32'h0000_8000);
	apb(0, phy_mode_control_off, 0);
	chk(rd[15], 1'b1);
	chk(o_phy_reset, 1'b1);
	repeat (20) @(posedge i_mclk);
	apb(0, phy_mode_control_off, 0);
	chk(rd, exp_ctl(3'h2));
	apb(0, strap_config_off, 0);
	chk(rd, {16'h0000, 3'h2, 13'h0000});
	$display("software reset done");
	apb(0, phy_mode_status_off, 0);
	link <= 0;
	fault <= 1;
	repeat (3) @(posedge i_mclk);
	link <= 1;
	fault <= 0;
	repeat (5) @(posedge i_mclk);
	apb(0, phy_mode_status_off, 0);
	chk(rd[2:1], 2'b10);
	apb(0, phy_mode_status_off, 0);
	chk(rd[2:1], 2'b01);
	$display("latched status done");
	end_sim();
end
endmodule // tb_phy_mode_control
